// >>> logic/appc_cfg.svh
// Purpose: constants of the aiding packet payload codec
// Assumes: included by bare name
// Notes: lengths are payload bytes
`ifndef APPC_CFG_SVH
`define APPC_CFG_SVH

// ==========================================================
// packet identifiers
`define APPC_ID_ANG_ACC 8'h2B
`define APPC_ID_POS_VEL 8'h2C
`define APPC_ID_POS 8'h2D
`define APPC_ID_VEL 8'h2E
`define APPC_ID_BODY_VEL 8'h2F
`define APPC_ID_HEADING 8'h30
`define APPC_ID_RUN_TIME 8'h31

// ==========================================================
// payload lengths in bytes
`define APPC_LEN_ANG_ACC 8'h0C
`define APPC_LEN_POS_VEL 8'h3C
`define APPC_LEN_POS 8'h24
`define APPC_LEN_VEL 8'h18
`define APPC_LEN_BODY_VEL 8'h10
`define APPC_LEN_HEADING 8'h08
`define APPC_LEN_RUN_TIME 8'h08

// ==========================================================
// field layout
`define APPC_WIDE_FIELDS 4'h3
`define APPC_WIDE_BYTES 4'h8
`define APPC_NARROW_BYTES 4'h4

`endif

// >>> logic/appc_pkg.sv
// Purpose: types of the aiding packet payload codec
// Assumes: nothing
// Notes: whole state is one struct
`default_nettype none
package appc_pkg;

	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_DROP} appc_rx_e;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} appc_tx_e;

	typedef struct packed {
		appc_rx_e rx_st;
		logic [7:0] rx_id;
		logic [7:0] rx_left;
		logic [3:0] rx_fidx;
		logic [3:0] rx_fcnt;
		logic [63:0] rx_sh;
		logic fld_valid;
		logic [3:0] fld_idx;
		logic [63:0] fld_data;
		logic fld_wide;
		logic pkt_done;
		logic pkt_bad;
		appc_tx_e tx_st;
		logic [7:0] tx_id;
		logic [7:0] tx_left;
		logic [3:0] tx_fidx;
		logic [3:0] tx_fcnt;
		logic [63:0] tx_sh;
		logic tx_ready;
		logic tx_bvalid;
		logic [7:0] tx_byte;
		logic tx_last;
		logic tx_rej;
	} appc_state_s;

endpackage : appc_pkg
`default_nettype wire

// >>> logic/appc_codec.sv
// Purpose: decode and encode payloads of the seven aiding packets
// Assumes: framing, checksum and header parsing done outside
// Notes: fields travel least significant byte first
`timescale 1ns/100ps
`default_nettype none
`include "appc_cfg.svh"

// ==========================================================
// Contract
// R01: id 43 carries 12 bytes, three fp32 angular accelerations at 0, 4, 8.
// R02: id 44 carries 60 bytes, fp64 latitude, longitude, height at 0, 8, 16.
// R03: id 44 fp32 NED velocities at 24..32, six fp32 deviations at 36..56.
// R04: id 45 carries 36 bytes, three fp64 positions, three fp32 deviations.
// R05: id 46 carries 24 bytes, three fp32 velocities then three deviations.
// R06: id 47 carries 16 bytes, fp32 body velocities X, Y, Z and one deviation.
// R07: id 48 carries 8 bytes, fp32 heading and its fp32 deviation.
// R08: id 49 carries 8 bytes, u32 seconds then u32 microseconds.
// R09: position deviations are fp32 metres although positions are fp64.
// R10: known id with wrong declared length is discarded and flagged malformed.
module appc_codec
	import appc_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// receive payload stream
	input wire logic RX_START,
	input wire logic [7:0] RX_ID,
	input wire logic [7:0] RX_LEN,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_BYTE,
	// decoded fields
	output logic FLD_VALID,
	output logic [3:0] FLD_INDEX,
	output logic [63:0] FLD_DATA,
	output logic FLD_WIDE,
	output logic PKT_DONE,
	output logic PKT_BAD,
	// fields to encode
	input wire logic TX_START,
	input wire logic [7:0] TX_ID,
	input wire logic TX_FIELD_VALID,
	input wire logic [63:0] TX_FIELD_DATA,
	output logic TX_FIELD_READY,
	output logic TX_REJECT,
	// encoded payload stream
	output logic TX_BYTE_VALID,
	output logic [7:0] TX_BYTE,
	output logic TX_LAST
);

	// ==========================================================
	// layout functions
	// fixed payload length per id, zero when unknown
	function automatic logic [7:0] pay_len(input logic [7:0] id);
		unique case (id)
			`APPC_ID_ANG_ACC: pay_len = `APPC_LEN_ANG_ACC; // R01
			`APPC_ID_POS_VEL: pay_len = `APPC_LEN_POS_VEL; // R02
			`APPC_ID_POS: pay_len = `APPC_LEN_POS; // R04
			`APPC_ID_VEL: pay_len = `APPC_LEN_VEL; // R05
			`APPC_ID_BODY_VEL: pay_len = `APPC_LEN_BODY_VEL; // R06
			`APPC_ID_HEADING: pay_len = `APPC_LEN_HEADING; // R07
			`APPC_ID_RUN_TIME: pay_len = `APPC_LEN_RUN_TIME; // R08
			default: pay_len = 8'h00;
		endcase
	endfunction : pay_len

	// only the position fields of 44 and 45 are eight bytes wide
	function automatic logic [3:0] fld_bytes(input logic [7:0] id, input logic [3:0] idx);
		if ((id == `APPC_ID_POS_VEL || id == `APPC_ID_POS) && idx < `APPC_WIDE_FIELDS) begin
			fld_bytes = `APPC_WIDE_BYTES; // R02 R04
		end else begin
			fld_bytes = `APPC_NARROW_BYTES; // R03 R09
		end
	endfunction : fld_bytes

	// ==========================================================
	// state
	appc_state_s s_reg;
	appc_state_s s_next;
	// next-state scratch values
	logic [63:0] rx_shift;
	logic [7:0] rx_plen;
	logic [7:0] tx_plen;

	always_comb begin
		s_next = s_reg;
		s_next.fld_valid = 1'b0;
		s_next.pkt_done = 1'b0;
		s_next.pkt_bad = 1'b0;
		s_next.tx_bvalid = 1'b0;
		s_next.tx_last = 1'b0;
		s_next.tx_rej = 1'b0;
		rx_shift = {RX_BYTE, s_reg.rx_sh[63:8]};
		rx_plen = pay_len(RX_ID);
		tx_plen = pay_len(TX_ID);

		// ======================================================
		// decoder
		unique case (s_reg.rx_st)
			RX_IDLE: begin
				if (RX_START && rx_plen != 8'h00) begin
					s_next.rx_id = RX_ID;
					s_next.rx_left = RX_LEN;
					s_next.rx_fidx = 4'h0;
					s_next.rx_fcnt = fld_bytes(RX_ID, 4'h0);
					if (RX_LEN == rx_plen) begin
						s_next.rx_st = RX_DATA;
					end else if (RX_LEN == 8'h00) begin
						// nothing to drop, flag at once
						s_next.pkt_bad = 1'b1; // R10
					end else begin
						// swallow the declared bytes to stay aligned
						s_next.rx_st = RX_DROP; // R10
					end
				end
			end
			RX_DATA: begin
				if (RX_VALID) begin
					s_next.rx_sh = rx_shift;
					s_next.rx_left = s_reg.rx_left - 8'h01;
					s_next.rx_fcnt = s_reg.rx_fcnt - 4'h1;
					if (s_reg.rx_fcnt == 4'h1) begin
						s_next.fld_valid = 1'b1;
						s_next.fld_idx = s_reg.rx_fidx;
						s_next.fld_wide = (fld_bytes(s_reg.rx_id, s_reg.rx_fidx)
							== `APPC_WIDE_BYTES);
						// narrow fields land in bits 31:0
						s_next.fld_data = s_next.fld_wide ? rx_shift : {32'h0, rx_shift[63:32]};
						s_next.rx_fidx = s_reg.rx_fidx + 4'h1;
						s_next.rx_fcnt = fld_bytes(s_reg.rx_id, s_reg.rx_fidx + 4'h1);
					end
					if (s_reg.rx_left == 8'h01) begin
						s_next.pkt_done = 1'b1;
						s_next.rx_st = RX_IDLE;
					end
				end
			end
			RX_DROP: begin
				if (RX_VALID) begin
					s_next.rx_left = s_reg.rx_left - 8'h01;
					if (s_reg.rx_left == 8'h01) begin
						s_next.pkt_bad = 1'b1; // R10
						s_next.rx_st = RX_IDLE;
					end
				end
			end
			default: s_next.rx_st = RX_IDLE;
		endcase

		// ======================================================
		// encoder
		unique case (s_reg.tx_st)
			TX_IDLE: begin
				if (TX_START) begin
					if (tx_plen == 8'h00) begin
						// unknown id refused, nothing sent
						s_next.tx_rej = 1'b1;
					end else begin
						s_next.tx_id = TX_ID;
						s_next.tx_left = tx_plen;
						s_next.tx_fidx = 4'h0;
						s_next.tx_ready = 1'b1;
						s_next.tx_st = TX_WAIT;
					end
				end
			end
			TX_WAIT: begin
				if (TX_FIELD_VALID) begin
					s_next.tx_sh = TX_FIELD_DATA;
					s_next.tx_fcnt = fld_bytes(s_reg.tx_id, s_reg.tx_fidx); // R09
					s_next.tx_ready = 1'b0;
					s_next.tx_st = TX_SEND;
				end
			end
			TX_SEND: begin
				s_next.tx_bvalid = 1'b1;
				s_next.tx_byte = s_reg.tx_sh[7:0];
				s_next.tx_sh = {8'h00, s_reg.tx_sh[63:8]};
				s_next.tx_fcnt = s_reg.tx_fcnt - 4'h1;
				s_next.tx_left = s_reg.tx_left - 8'h01;
				// final payload byte ends the packet
				if (s_reg.tx_left == 8'h01) begin
					s_next.tx_last = 1'b1;
					s_next.tx_st = TX_IDLE;
				end else if (s_reg.tx_fcnt == 4'h1) begin
					// ready rises with the last byte of a field
					s_next.tx_fidx = s_reg.tx_fidx + 4'h1;
					s_next.tx_ready = 1'b1;
					s_next.tx_st = TX_WAIT;
				end
			end
			default: s_next.tx_st = TX_IDLE;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs
	assign FLD_VALID = s_reg.fld_valid;
	assign FLD_INDEX = s_reg.fld_idx;
	assign FLD_DATA = s_reg.fld_data;
	assign FLD_WIDE = s_reg.fld_wide;
	assign PKT_DONE = s_reg.pkt_done;
	assign PKT_BAD = s_reg.pkt_bad;
	assign TX_FIELD_READY = s_reg.tx_ready;
	assign TX_REJECT = s_reg.tx_rej;
	assign TX_BYTE_VALID = s_reg.tx_bvalid;
	assign TX_BYTE = s_reg.tx_byte;
	assign TX_LAST = s_reg.tx_last;

endmodule : appc_codec
`default_nettype wire

// >>> verif/appc_codec_sva.sv
// Purpose: port checks of the payload codec
// Assumes: one clock domain
// Notes: bound into every appc_codec
`timescale 1ns/100ps
`default_nettype none
module appc_codec_sva (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// decoder side
	input wire logic FLD_VALID,
	input wire logic [3:0] FLD_INDEX,
	input wire logic [63:0] FLD_DATA,
	input wire logic FLD_WIDE,
	input wire logic PKT_DONE,
	input wire logic PKT_BAD,
	// encoder side
	input wire logic TX_FIELD_VALID,
	input wire logic TX_FIELD_READY,
	input wire logic TX_BYTE_VALID,
	input wire logic TX_LAST
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	done_with_field_a: assert property (PKT_DONE |-> FLD_VALID) else $error("done alone");
	field_spacing_a: assert property (FLD_VALID |=> !FLD_VALID [*3]) else $error("fields close");
	narrow_upper_a: assert property (FLD_VALID && !FLD_WIDE |-> FLD_DATA[63:32] == 32'h0)
		else $error("narrow high");
	wide_index_a: assert property (FLD_VALID && FLD_WIDE |-> FLD_INDEX < 4'h3)
		else $error("wide index");
	bad_alone_a: assert property (PKT_BAD |-> !FLD_VALID && !PKT_DONE) else $error("bad");
	byte_burst_a: assert property (TX_FIELD_VALID && TX_FIELD_READY |=>
		!TX_BYTE_VALID ##1 TX_BYTE_VALID [*4]) else $error("burst");
	last_on_byte_a: assert property (TX_LAST |-> TX_BYTE_VALID) else $error("last");
	busy_ready_a: assert property (TX_FIELD_READY |=> !TX_BYTE_VALID) else $error("ready");
endmodule : appc_codec_sva
bind appc_codec appc_codec_sva u_sva (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
	.FLD_VALID(FLD_VALID), .FLD_INDEX(FLD_INDEX), .FLD_DATA(FLD_DATA), .FLD_WIDE(FLD_WIDE),
	.PKT_DONE(PKT_DONE), .PKT_BAD(PKT_BAD), .TX_FIELD_VALID(TX_FIELD_VALID),
	.TX_FIELD_READY(TX_FIELD_READY), .TX_BYTE_VALID(TX_BYTE_VALID), .TX_LAST(TX_LAST));
`default_nettype wire

// >>> verif/appc_host.sv
// Purpose: host side sink of encoded bytes
// Assumes: bytes arrive one per cycle
// Notes: keeps all bytes for the bench
`timescale 1ns/100ps
`default_nettype none
module appc_host (
	// byte stream
	input wire logic clk,
	input wire logic v,
	input wire logic last,
	input wire logic [7:0] b
);
	logic [7:0] q [$];
	int nl = 0;
	always @(posedge clk) begin
		if (v === 1'b1) q.push_back(b);
		if (last === 1'b1) nl++;
	end
endmodule : appc_host
`default_nettype wire

// >>> verif/test_appc_codec.sv
// Purpose: self-checking bench of the payload codec
// Assumes: inputs change on falling edges
// Notes: byte i of a packet to decode is id plus i
`timescale 1ns/100ps
`default_nettype none
module test_appc_codec;
	logic clk = 0, rst_n = 0, rx_start = 0, rx_valid = 0, tx_start = 0, tx_fv = 0;
	logic [7:0] rx_id = 0, rx_len = 0, rx_byte = 0, tx_id = 0, tx_b;
	logic [63:0] tx_fd = 0, fld_d;
	logic [3:0] fld_i;
	logic fld_v, fld_w, done, bad, tx_rdy, rej, tx_bv, tx_last;
	logic [63:0] fq [$];
	logic [4:0] iq [$];
	int n_fail = 0, num_checks = 0, dn, bd;
	appc_codec dut (.SYS_CLK(clk), .RESETN(rst_n), .RX_START(rx_start), .RX_ID(rx_id),
		.RX_LEN(rx_len), .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .FLD_VALID(fld_v),
		.FLD_INDEX(fld_i), .FLD_DATA(fld_d), .FLD_WIDE(fld_w), .PKT_DONE(done), .PKT_BAD(bad),
		.TX_START(tx_start), .TX_ID(tx_id), .TX_FIELD_VALID(tx_fv), .TX_FIELD_DATA(tx_fd),
		.TX_FIELD_READY(tx_rdy), .TX_REJECT(rej), .TX_BYTE_VALID(tx_bv), .TX_BYTE(tx_b),
		.TX_LAST(tx_last));
	appc_host host (.clk(clk), .v(tx_bv), .last(tx_last), .b(tx_b));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (fld_v === 1'b1) begin
			fq.push_back(fld_d);
			iq.push_back({fld_w, fld_i});
		end
		if (done === 1'b1) dn++;
		if (bad === 1'b1) bd++;
	end
	task chk(input logic [63:0] seen, exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task send(input logic [7:0] id, n);
		fq = {};
		iq = {};
		dn = 0;
		bd = 0;
		@(negedge clk);
		rx_start = 1;
		rx_id = id;
		rx_len = n;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			rx_start = 0;
			rx_valid = 1;
			rx_byte = id + 8'(i);
		end
		@(negedge clk);
		rx_valid = 0;
		rx_start = 0;
		repeat (3) @(negedge clk);
	endtask : send
	task automatic test_rx;
		logic [7:0] len [7] = '{8'h0C, 8'h3C, 8'h24, 8'h18, 8'h10, 8'h08, 8'h08};
		logic [63:0] e;
		int o;
		int w;
		for (int p = 0; p < 7; p++) begin
			w = (p == 1 || p == 2) ? 3 : 0;
			send(8'h2B + 8'(p), len[p]);
			o = 0;
			foreach (fq[f]) begin
				e = 0;
				for (int k = (f < w) ? 7 : 3; k >= 0; k--) begin
					e = {e[55:0], 8'h2B + 8'(p + o + k)};
				end
				chk(fq[f], e, "field");
				chk(64'(iq[f]), {59'h0, f < w, 4'(f)}, "index");
				o += (f < w) ? 8 : 4;
			end
			chk(64'(o), 64'(len[p]), "bytes");
			chk(64'(dn), 64'h1, "done");
		end
		$display("test_rx done");
	endtask : test_rx
	task test_bad;
		send(8'h2C, 8'h0C);
		chk(64'(fq.size()), 64'h0, "fields");
		chk(64'(bd), 64'h1, "bad");
		chk(64'(dn), 64'h0, "done");
		send(8'h30, 8'h00);
		chk(64'(fq.size()), 64'h0, "empty fields");
		chk(64'(bd), 64'h1, "empty bad");
		send(8'h32, 8'h08);
		chk(64'(fq.size()), 64'h0, "unknown fields");
		chk(64'(bd + dn), 64'h0, "unknown flags");
		$display("test_bad done");
	endtask : test_bad
	task automatic xmit(input logic [7:0] id, input int nf, input int w);
		logic [63:0] d;
		int b0;
		int l0;
		int o;
		b0 = host.q.size();
		l0 = host.nl;
		@(negedge clk);
		tx_start = 1;
		tx_id = id;
		@(negedge clk);
		tx_start = 0;
		chk(64'(tx_rdy), 64'h1, "ready");
		for (int f = 0; f < nf; f++) begin
			for (int t = 0; t < 20 && tx_rdy !== 1'b1; t++) @(negedge clk);
			for (int j = 0; j < 8; j++) d[8 * j +: 8] = 8'(16 * f + j + 1);
			tx_fv = 1;
			tx_fd = d;
			@(negedge clk);
			tx_fv = 0;
		end
		repeat (10) @(negedge clk);
		o = b0;
		for (int f = 0; f < nf; f++) begin
			for (int j = 0; j < ((f < w) ? 8 : 4); j++) begin
				chk(64'(host.q[o]), 64'(16 * f + j + 1), "byte");
				o++;
			end
		end
		chk(64'(host.q.size() - b0), 64'(o - b0), "count");
		chk(64'(host.nl - l0), 64'h1, "last");
		chk(64'(tx_rdy), 64'h0, "idle ready");
	endtask : xmit
	task test_tx;
		xmit(8'h31, 2, 0);
		xmit(8'h2D, 6, 3);
		@(negedge clk);
		tx_start = 1;
		tx_id = 8'h32;
		@(negedge clk);
		tx_start = 0;
		chk(64'(rej), 64'h1, "reject");
		@(negedge clk);
		chk(64'(rej), 64'h0, "reject pulse");
		chk(64'(tx_rdy), 64'h0, "reject ready");
		$display("test_tx done");
	endtask : test_tx
	task conclude;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		test_rx();
		test_bad();
		test_tx();
		conclude();
	end
endmodule : test_appc_codec
`default_nettype wire
